//--- verilog/mcr_pkg.sv
`default_nettype none
package mcr_pkg;

  // core clock
  localparam int unsigned CLK_HZ = 25_000_000;

  // register geometry
  localparam int unsigned REG_W    = 16;
  localparam int unsigned NUM_CTRL = 12;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned FAULT_W  = 6;

  // register offsets
  localparam logic [6:0] ADDR_CTRL_LAST = 7'h0b;
  localparam logic [6:0] ADDR_FAULT     = 7'h2a;
  localparam logic [6:0] ADDR_OTP_KEY   = 7'h7f;

  // reset values
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] FAULT_RESET = 16'h0018;

  // register 0 fields
  localparam int unsigned AGS_LSB             = 12;
  localparam int unsigned AGS_W               = 4;
  localparam int unsigned ENABLE_POLARITY_BIT = 11;
  localparam int unsigned DIRSENSE_BIT        = 10;

  // fault register fields
  localparam int unsigned OVERCURRENT_BIT      = 0;
  localparam int unsigned PUMP_OVERCURRENT_BIT = 1;
  localparam int unsigned OVERTEMP_BIT         = 2;
  localparam int unsigned UNDERVOLTAGE_BIT     = 3;
  localparam int unsigned PUMP_FAILURE_BIT     = 4;
  localparam int unsigned SUPPLY_OVERVOLT_BIT  = 5;

  // serial frame layout
  localparam logic [4:0] FRAME_BITS  = 5'h18;
  localparam logic [4:0] READ_LOAD   = 5'h07;
  localparam logic [4:0] READ_SHIFT  = 5'h09;
  localparam int unsigned RW_POS     = 23;
  localparam int unsigned ADDR_LSB   = 16;

  // permanent-memory unlock sequence
  localparam logic [15:0] OTP_KEY [5] = '{16'h1213, 16'h1415, 16'h1617,
                                          16'h1819, 16'h0002};
  localparam logic [2:0]  OTP_KEY_LAST = 3'h4;
  localparam logic [15:0] OTP_FINAL    = 16'h0edd;
  localparam int unsigned OTP_WAIT_MS  = 10;
  localparam int unsigned OTP_WAIT_CYC = (CLK_HZ / 1000) * OTP_WAIT_MS;

  // external memory fetch
  localparam logic [2:0] EE_HALF_LAST = 3'h3;
  localparam logic [8:0] EE_CMD       = 9'h180;
  localparam logic [7:0] EE_CMD_LAST  = 8'h08;
  localparam logic [7:0] EE_DATA_LAST = 8'hbf;

  // autogain setpoint decode, hertz
  localparam logic [16:0] AGS_HZ [16] = '{
    17'h00003, 17'h00006, 17'h0000c, 17'h00018,
    17'h00030, 17'h0005f, 17'h000bf, 17'h0017e,
    17'h002fb, 17'h005dc, 17'h00bb8, 17'h01770,
    17'h02ee0, 17'h05dc0, 17'h0bf68, 17'h17ed0};

  typedef logic [NUM_CTRL-1:0][REG_W-1:0] mcr_cfg_t;

  typedef struct packed {
    logic sel;
    logic sclk;
    logic sdat;
  } mcr_spi_pins_t;

  typedef enum logic [1:0] {
    OTP_IDLE  = 2'b00,
    OTP_WAIT  = 2'b01,
    OTP_ARMED = 2'b10,
    OTP_DONE  = 2'b11
  } mcr_otp_state_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_CMD  = 2'b01,
    LD_DATA = 2'b10
  } mcr_ld_state_t;

endpackage
`default_nettype wire

//--- verilog/mcr_config_regs.sv
// Contract
// R1: host fills registers before permanent programming
// R2: host holds enable active during programming
// R3: five key writes, 10 ms pause, final write
// R4: permanent programming accepted once only
// R5: registers stay writable and loadable after programming
// R6: reload on power-up, supply rise, reset toggle
// R7: unprogrammed default zero, fault register 0x18
// R8: fault flags cleared by zero, never set
// R9: serial writes overwrite registers any time; ignored here while a fetch runs or source select is high
// R10: twelve control registers plus fault register
// R11: autogain setpoint decodes doubling frequencies
// R12: register zero bit 11 picks enable polarity
// R13: register zero bit 10 inverts direction
// R14: configure by serial, permanent memory, external memory
// R15: abandon unlock on any deviation
// R16: 24-bit frame: rw, address, data
// R17: commit write when select falls
// R18: source select high fetches external memory
// R19: read returns register on data out
`timescale 1ns/1ps
`default_nettype none
module mcr_config_regs #(
  parameter int unsigned OTP_WAIT_CYCLES = mcr_pkg::OTP_WAIT_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire mcr_pkg::mcr_spi_pins_t spi_i,
  input  wire logic                  config_source_select_i,
  input  wire logic                  enable_i,
  input  wire logic                  direction_i,
  input  wire logic                  motor_supply_ok_i,
  input  wire logic                  reset_pin_i,
  input  wire logic [5:0]            fault_event_i,
  output logic                       serial_data_out_o,
  output logic                       serial_select_o,
  output logic                       serial_select_oe_o,
  output logic                       serial_clk_o,
  output logic                       serial_clk_oe_o,
  output mcr_pkg::mcr_cfg_t          cfg_o,
  output logic [15:0]                fault_flags_o,
  output logic [16:0]                autogain_hz_o,
  output logic                       device_active_o,
  output logic                       direction_o,
  output logic                       otp_programmed_o,
  output logic                       loading_o
);
  import mcr_pkg::*;

  logic [13:0]    sync_raw;
  logic [13:0]    sync_meta;
  logic [13:0]    sync_q;
  logic [13:0]    sync_d;
  logic           sel_s;
  logic           sclk_s;
  logic           sdat_s;
  logic           src_sel_s;
  logic           enable_s;
  logic           dir_s;
  logic           supply_s;
  logic           rstpin_s;
  logic [5:0]     fault_ev_s;
  logic           sel_rise;
  logic           sel_fall;
  logic           sclk_rise;
  logic           sclk_fall;
  logic [4:0]     bit_cnt;
  logic [23:0]    shreg;
  logic [15:0]    rd_sh;
  logic [6:0]     next_addr;
  logic           slave_en;
  logic           frame_done;
  logic           wr_ev;
  logic [6:0]     f_addr;
  logic [15:0]    f_data;
  logic           key_wr;
  mcr_cfg_t       cfg;
  mcr_cfg_t       otp_mem;
  logic [15:0]    fault;
  mcr_ld_state_t  ld_state;
  logic [1:0]     boot_cnt;
  logic [2:0]     ee_div;
  logic           ee_sclk;
  logic           ee_cs;
  logic [7:0]     ee_cnt;
  logic [8:0]     ee_cmd_sh;
  logic [14:0]    ee_sh;
  logic           ee_fall;
  logic           ee_word_wr;
  logic [15:0]    ee_word;
  logic           load_req;
  logic           apply_now;
  mcr_otp_state_t otp_state;
  logic [2:0]     key_idx;
  logic [31:0]    wait_cnt;
  logic           otp_prog;
  logic           otp_commit;
  logic           dev_act;

  assign sync_raw = {spi_i.sel, spi_i.sclk, spi_i.sdat, config_source_select_i,
                     enable_i, direction_i, motor_supply_ok_i, reset_pin_i,
                     fault_event_i};

  // three stages; nothing looks at the first one
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sync_meta <= 14'h0000;
      sync_q    <= 14'h0000;
      sync_d    <= 14'h0000;
    end else begin
      sync_meta <= sync_raw;
      sync_q    <= sync_meta;
      sync_d    <= sync_q;
    end
  end

  assign sel_s      = sync_q[13];
  assign sclk_s     = sync_q[12];
  assign sdat_s     = sync_q[11];
  assign src_sel_s  = sync_q[10];
  assign enable_s   = sync_q[9];
  assign dir_s      = sync_q[8];
  assign supply_s   = sync_q[7];
  assign rstpin_s   = sync_q[6];
  assign fault_ev_s = sync_q[5:0];
  assign sel_rise   = sel_s & ~sync_d[13];
  assign sel_fall   = ~sel_s & sync_d[13];
  assign sclk_rise  = sclk_s & ~sync_d[12];
  assign sclk_fall  = ~sclk_s & sync_d[12];

  // slave only while not fetching and not strapped as master
  assign slave_en   = (ld_state == LD_IDLE) && !src_sel_s;
  assign next_addr  = {shreg[5:0], sdat_s};
  assign f_addr     = shreg[RW_POS-1:ADDR_LSB];
  assign f_data     = shreg[15:0];
  assign frame_done = sel_fall && slave_en && (bit_cnt == FRAME_BITS); // [R17]
  assign wr_ev      = frame_done && !shreg[RW_POS]; // [R16]
  assign key_wr     = wr_ev && (f_addr == ADDR_OTP_KEY);
  assign dev_act    = enable_s ^ cfg[0][ENABLE_POLARITY_BIT]; // [R12]

  function automatic logic [15:0] rd_word(input logic [6:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a <= ADDR_CTRL_LAST) begin
      v = cfg[a[3:0]];
    end else if (a == ADDR_FAULT) begin
      v = fault;
    end
    return v;
  endfunction
  // extra edges past the 24th are dropped, short frames never commit
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      bit_cnt <= 5'h00;
      shreg   <= 24'h000000;
    end else if (sel_rise) begin
      bit_cnt <= 5'h00;
    end else if (sel_s && sclk_rise && slave_en && bit_cnt != FRAME_BITS) begin
      shreg   <= {shreg[22:0], sdat_s}; // [R16]
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // read data snapped once the address is in, data bits in are ignored
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rd_sh <= 16'h0000;
    end else if (sel_s && sclk_rise && slave_en && bit_cnt == READ_LOAD) begin
      rd_sh <= shreg[6] ? rd_word(next_addr) : 16'h0000; // [R19]
    end else if (sel_s && sclk_fall && bit_cnt >= READ_SHIFT) begin
      rd_sh <= {rd_sh[14:0], 1'b0}; // [R19]
    end
  end

  // one pin, two jobs: command to external memory or read data to host
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      serial_data_out_o <= 1'b0;
    end else if (ld_state == LD_CMD) begin
      serial_data_out_o <= ee_cmd_sh[8]; // [R18]
    end else begin
      serial_data_out_o <= rd_sh[15]; // [R19]
    end
  end

  // reload triggers; boot waits for the strap synchroniser to settle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      boot_cnt <= 2'h3;
    end else if (boot_cnt != 2'h0) begin
      boot_cnt <= boot_cnt - 2'h1;
    end
  end

  assign load_req = (boot_cnt == 2'h1)
                  || (supply_s && !sync_d[7])
                  || (!rstpin_s && sync_d[6]); // [R6]
  assign apply_now = load_req && !src_sel_s && (ld_state == LD_IDLE);
  assign ee_fall    = (ee_div == EE_HALF_LAST) && ee_sclk;
  assign ee_word    = {ee_sh, sdat_s};
  assign ee_word_wr = (ld_state == LD_DATA) && ee_fall
                      && (ee_cnt[3:0] == 4'hf);

  // master fetch: one read command, then twelve words streamed back
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ld_state  <= LD_IDLE;
      ee_div    <= 3'h0;
      ee_sclk   <= 1'b0;
      ee_cs     <= 1'b0;
      ee_cnt    <= 8'h00;
      ee_cmd_sh <= 9'h000;
      ee_sh     <= 15'h0000;
    end else begin
      case (ld_state)
        LD_IDLE: begin
          if (load_req && src_sel_s) begin
            ld_state  <= LD_CMD; // [R18]
            ee_cs     <= 1'b1;
            ee_cmd_sh <= EE_CMD;
            ee_cnt    <= 8'h00;
            ee_div    <= 3'h0;
            ee_sclk   <= 1'b0;
          end
        end
        LD_CMD, LD_DATA: begin
          if (ee_div == EE_HALF_LAST) begin
            ee_div  <= 3'h0;
            ee_sclk <= ~ee_sclk;
          end else begin
            ee_div <= ee_div + 3'h1;
          end
          if (ee_fall && ld_state == LD_CMD) begin
            ee_cmd_sh <= {ee_cmd_sh[7:0], 1'b0};
            if (ee_cnt == EE_CMD_LAST) begin
              ld_state <= LD_DATA;
              ee_cnt   <= 8'h00;
            end else begin
              ee_cnt <= ee_cnt + 8'h01;
            end
          end else if (ee_fall) begin
            // data latched on the falling clock edge
            ee_sh  <= ee_word[14:0];
            ee_cnt <= ee_cnt + 8'h01;
            if (ee_cnt == EE_DATA_LAST) begin
              ld_state <= LD_IDLE;
              ee_cs    <= 1'b0;
            end
          end
        end
        default: begin
          ld_state <= LD_IDLE;
          ee_cs    <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cfg <= {NUM_CTRL{CTRL_RESET}}; // [R7]
    end else if (apply_now) begin
      cfg <= otp_prog ? otp_mem : {NUM_CTRL{CTRL_RESET}}; // [R6] [R7] [R14]
    end else if (ee_word_wr) begin
      cfg[ee_cnt[7:4]] <= ee_word; // [R5] [R14]
    end else if (wr_ev && f_addr <= ADDR_CTRL_LAST) begin
      cfg[f_addr[3:0]] <= f_data; // [R9] [R10] [R5]
    end
  end

  // fault flags: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      fault <= FAULT_RESET; // [R7]
    end else if (apply_now && !otp_prog) begin
      fault <= FAULT_RESET | {10'h000, fault_ev_s}; // [R7]
    end else if (wr_ev && f_addr == ADDR_FAULT) begin
      fault <= (fault & {10'h000, f_data[FAULT_W-1:0]})
             | {10'h000, fault_ev_s}; // [R8] [R10]
    end else begin
      fault <= fault | {10'h000, fault_ev_s}; // [R10]
    end
  end

  always_ff @(posedge clk_i) begin
    if (otp_commit) begin
      otp_mem <= cfg; // [R1] [R14]
    end
  end
  assign otp_commit = (otp_state == OTP_ARMED) && dev_act && key_wr
                      && (f_data == OTP_FINAL); // [R3]
  // the programmed flag models the fuse; only a core reset clears it
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      otp_state <= OTP_IDLE;
      key_idx   <= 3'h0;
      wait_cnt  <= 32'h00000000;
      otp_prog  <= 1'b0;
    end else begin
      case (otp_state)
        OTP_IDLE: begin
          if (!dev_act) begin
            key_idx <= 3'h0; // [R2] [R15]
          end else if (frame_done) begin
            if (key_wr && f_data == OTP_KEY[key_idx]) begin
              if (key_idx == OTP_KEY_LAST) begin
                otp_state <= OTP_WAIT; // [R3]
                key_idx   <= 3'h0;
                wait_cnt  <= 32'h00000000;
              end else begin
                key_idx <= key_idx + 3'h1; // [R3]
              end
            end else begin
              key_idx <= 3'h0; // [R15]
            end
          end
        end
        OTP_WAIT: begin
          // any frame inside the pause, the final key too, aborts
          if (!dev_act || frame_done) begin
            otp_state <= OTP_IDLE; // [R15]
          end else if (wait_cnt == 32'(OTP_WAIT_CYCLES - 1)) begin
            otp_state <= OTP_ARMED; // [R3]
          end else begin
            wait_cnt <= wait_cnt + 32'h00000001;
          end
        end
        OTP_ARMED: begin
          if (otp_commit) begin
            otp_state <= OTP_DONE;
            otp_prog  <= 1'b1; // [R3]
          end else if (!dev_act || frame_done) begin
            otp_state <= OTP_IDLE; // [R15]
          end
        end
        OTP_DONE: begin
          otp_state <= OTP_DONE; // [R4]
        end
        default: begin
          otp_state <= OTP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      autogain_hz_o   <= AGS_HZ[0];
      device_active_o <= 1'b0;
      direction_o     <= 1'b0;
      loading_o       <= 1'b0;
    end else begin
      autogain_hz_o   <= AGS_HZ[cfg[0][AGS_LSB +: AGS_W]]; // [R11]
      device_active_o <= dev_act; // [R12]
      direction_o     <= dir_s ^ cfg[0][DIRSENSE_BIT]; // [R13]
      loading_o       <= (ld_state != LD_IDLE);
    end
  end

  assign serial_select_o    = ee_cs;
  assign serial_select_oe_o = ee_cs;
  assign serial_clk_o       = ee_sclk;
  assign serial_clk_oe_o    = ee_cs;
  assign cfg_o              = cfg;
  assign fault_flags_o      = fault;
  assign otp_programmed_o   = otp_prog;

endmodule
`default_nettype wire

//--- dv/mcr_config_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_config_regs_props #(
  parameter int unsigned OTP_WAIT_CYCLES = 20
) (
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire logic              enable_i,
  input wire logic              direction_i,
  input wire logic              config_source_select_i,
  input wire logic [5:0]        fault_event_i,
  input wire mcr_pkg::mcr_cfg_t cfg_o,
  input wire logic [15:0]       fault_flags_o,
  input wire logic              device_active_o,
  input wire logic              direction_o,
  input wire logic              otp_programmed_o,
  input wire logic              loading_o,
  input wire logic              serial_clk_o,
  input wire logic              serial_clk_oe_o,
  input wire logic              serial_select_oe_o
);
  import mcr_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_hi;
    fault_flags_o[15:6] == 10'h000;
  endproperty
  a_hi: assert property (p_hi)
    else $error("fault high bits set");
  // slack of five cycles covers the pin synchronisers
  property p_set;
    $stable(fault_event_i)[*5]
      |-> (fault_flags_o[5:0] & fault_event_i) == fault_event_i;
  endproperty
  a_set: assert property (p_set)
    else $error("fault event not flagged");
  property p_dir;
    ($stable(direction_i) && $stable(cfg_o[0][10]))[*5]
      |-> direction_o == (direction_i ^ cfg_o[0][10]);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction sense wrong");
  property p_act;
    ($stable(enable_i) && $stable(cfg_o[0][11]))[*5]
      |-> device_active_o == (enable_i ^ cfg_o[0][11]);
  endproperty
  a_act: assert property (p_act)
    else $error("enable polarity wrong");
  property p_oe;
    $rose(serial_select_oe_o) |=> loading_o && serial_clk_oe_o;
  endproperty
  a_oe: assert property (p_oe)
    else $error("master enables differ");
  property p_nofetch;
    (!config_source_select_i)[*6] |-> !$rose(loading_o);
  endproperty
  a_nofetch: assert property (p_nofetch)
    else $error("fetch without source select");
  property p_once;
    otp_programmed_o |=> otp_programmed_o;
  endproperty
  a_once: assert property (p_once)
    else $error("programmed flag dropped");
  property p_half;
    $changed(serial_clk_o) |=> $stable(serial_clk_o)[*3];
  endproperty
  a_half: assert property (p_half)
    else $error("fetch clock half period wrong");

  c_prog: cover property ($rose(otp_programmed_o));
  c_fetch: cover property ($fell(loading_o));
  c_clear: cover property (fault_flags_o == 16'h0000);
endmodule

bind mcr_config_regs mcr_config_regs_props #(
  .OTP_WAIT_CYCLES(OTP_WAIT_CYCLES)
) i_props (
  .clk_i, .nrst_i, .enable_i, .direction_i, .config_source_select_i,
  .fault_event_i, .cfg_o, .fault_flags_o, .device_active_o,
  .direction_o, .otp_programmed_o, .loading_o, .serial_clk_o,
  .serial_clk_oe_o, .serial_select_oe_o
);
`default_nettype wire

//--- dv/mcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model #(
  parameter int unsigned WAIT_CYC = 20
) (
  input  wire logic                   clk_i,
  input  wire logic                   serial_data_out_i,
  input  wire logic                   ee_sel_i,
  input  wire logic                   ee_clk_i,
  output wire mcr_pkg::mcr_spi_pins_t spi_o
);
  import mcr_pkg::*;
  logic        sel = 1'b0;
  logic        sck = 1'b0;
  logic        hd  = 1'b0;
  logic        ed  = 1'b0;
  logic        tg  = 1'b0;
  logic [15:0] mem [12];
  int          r   = 0;
  wire logic   sd;

  // a released line toggles so a stale level never passes
  always @(posedge clk_i) tg <= ~tg;
  assign sd = sel ? hd : (ee_sel_i ? ed : tg);
  assign spi_o = {sel, sck, sd};

  // memory side: nine command clocks, then words MSB first
  always @(posedge ee_clk_i or negedge ee_sel_i) begin
    if (!ee_sel_i) begin
      r = 0;
    end else begin
      r = r + 1;
      if (r >= 10 && r < 202) begin
        ed <= mem[(r - 10) / 16][15 - (r - 10) % 16];
      end
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // n below 24 gives a frame the device must drop
  task automatic xfer(input logic rw, input logic [6:0] a,
                      input logic [15:0] d, input int n,
                      output logic [15:0] q);
    logic [23:0] f;
    f = {rw, a, d};
    q = 16'h0000;
    sel = 1'b1;
    for (int i = 0; i < n; i++) begin
      hd = f[23 - i];
      cyc(5);
      if (i > 7) q = {q[14:0], serial_data_out_i};
      sck = 1'b1;
      cyc(5);
      sck = 1'b0;
    end
    cyc(4);
    sel = 1'b0;
    cyc(8);
  endtask

  // bad spoils the third key word
  task automatic otp_seq(input logic [15:0] bad);
    logic [15:0] q;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, ADDR_OTP_KEY, OTP_KEY[i] ^ (i == 2 ? bad : 16'h0000),
           24, q);
    end
    cyc(WAIT_CYC + 4);
    xfer(1'b0, ADDR_OTP_KEY, OTP_FINAL, 24, q);
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mcr_pkg::*;
  localparam int unsigned WAITC = 20;
  localparam int HZ [16] = '{3, 6, 12, 24, 48, 95, 191, 382, 763, 1500,
    3000, 6000, 12000, 24000, 49000, 98000};
  logic          clk_i = 1'b0;
  logic          nrst_i = 1'b0;
  logic          src = 1'b0;
  logic          en = 1'b1;
  logic          dir = 1'b0;
  logic          vok = 1'b1;
  logic          rstp = 1'b0;
  logic [5:0]    ev = 6'h00;
  wire mcr_spi_pins_t spi;
  mcr_cfg_t      cfg;
  logic [15:0]   flt;
  logic [15:0]   q;
  logic [16:0]   ags;
  logic          sdo, cs, cs_oe, sck, sck_oe, act, dro, prog, ld;
  int            miscompares = 0;
  int            total_checks = 0;
  int            m [13];
  int            snap [12];
  int            eq [$];
  int            pm = 0;

  always #20 clk_i = ~clk_i;

  mcr_config_regs #(.OTP_WAIT_CYCLES(WAITC)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .spi_i(spi),
    .config_source_select_i(src), .enable_i(en), .direction_i(dir),
    .motor_supply_ok_i(vok), .reset_pin_i(rstp), .fault_event_i(ev),
    .serial_data_out_o(sdo), .serial_select_o(cs),
    .serial_select_oe_o(cs_oe), .serial_clk_o(sck),
    .serial_clk_oe_o(sck_oe), .cfg_o(cfg), .fault_flags_o(flt),
    .autogain_hz_o(ags), .device_active_o(act), .direction_o(dro),
    .otp_programmed_o(prog), .loading_o(ld));

  mcr_host_model #(.WAIT_CYC(WAITC)) i_host (
    .clk_i(clk_i), .serial_data_out_i(sdo), .ee_sel_i(cs & cs_oe),
    .ee_clk_i(sck & sck_oe), .spi_o(spi));

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [16:0] g, input logic [16:0] e,
                     input int id);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t item %0d got %h exp %h", $time, id, g, e);
    end
  endtask

  task automatic chk_all;
    for (int i = 0; i < 12; i++) chk(cfg[i], 17'(m[i]), i);
    chk(flt, 17'(m[12]), 12);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_host.xfer(1'b0, a, d, 24, q);
    if (a <= ADDR_CTRL_LAST) m[a] = d;
    if (a == ADDR_FAULT) m[12] = (m[12] & d & 63) | ev;
  endtask

  task automatic rd(input logic [6:0] a, input int e);
    i_host.xfer(1'b1, a, 16'hffff, 24, q);
    chk(q, 17'(e), a);
  endtask

  task automatic wait_ld(input logic v, input int n);
    int k;
    k = 0;
    while (ld !== v && k < n) begin
      cyc(1);
      k++;
    end
    if (ld !== v) begin
      miscompares++;
      $display("CHECK FAILED %0t fetch wait ran out", $time);
      final_report();
    end
  endtask

  // reset pin toggle; model picks the source as the device should
  task automatic reload;
    rstp = 1'b1;
    cyc(3);
    rstp = 1'b0;
    for (int i = 0; i < 12; i++) m[i] = src ? eq[i] : (pm ? snap[i] : 0);
    if (!src && !pm) m[12] = 24 | ev;
    if (src) begin
      wait_ld(1'b1, 50);
      wait_ld(1'b0, 4000);
    end
    cyc(8);
  endtask

  initial begin
    logic [15:0] d;
    void'($urandom(32'h7059));
    cyc(2);
    nrst_i = 1'b1;
    cyc(6);
    for (int i = 0; i < 12; i++) m[i] = 0;
    m[12] = 24;
    chk_all();
    for (int i = 0; i < 13; i++) begin
      wr(i < 12 ? 7'(i) : ADDR_FAULT, 16'($urandom));
    end
    chk_all();
    for (int i = 0; i < 13; i++) begin
      rd(i < 12 ? 7'(i) : ADDR_FAULT, m[i]);
    end
    wr(7'h0c, 16'hffff);
    wr(7'h2b, 16'hffff);
    rd(7'h29, 0);
    i_host.xfer(1'b0, 7'h01, ~m[1][15:0], 23, q);
    chk_all();
    wr(ADDR_FAULT, 16'hffff);
    chk(flt, 17'(m[12]), 13);
    ev = 6'h21;
    cyc(6);
    wr(ADDR_FAULT, 16'h0000);
    ev = 6'h00;
    cyc(6);
    chk(flt, 17'h00021, 14);
    wr(ADDR_FAULT, 16'h0000);
    chk(flt, 17'h00000, 15);
    for (int c = 0; c < 16; c++) begin
      dir = 1'($urandom);
      wr(7'h00, {4'(c), 1'(c), 1'(c >> 1), 10'h000});
      chk(ags, 17'(HZ[c]), c);
      chk(act, en ^ c[0], c);
      chk(dro, dir ^ c[1], c);
    end
    wr(7'h00, 16'h0000);
    i_host.otp_seq(16'h0001);
    chk(prog, 17'h0, 20);
    en = 1'b0;
    i_host.otp_seq(16'h0000);
    chk(prog, 17'h0, 21);
    en = 1'b1;
    wr(7'h05, 16'($urandom));
    i_host.otp_seq(16'h0000);
    chk(prog, 17'h1, 22);
    pm = 1;
    for (int i = 0; i < 12; i++) snap[i] = m[i];
    wr(7'h05, 16'h5a5a);
    chk_all();
    reload();
    chk_all();
    wr(7'h02, 16'ha5a5);
    i_host.otp_seq(16'h0000);
    reload();
    chk_all();
    wr(7'h03, 16'h3c3c);
    vok = 1'b0;
    cyc(4);
    vok = 1'b1;
    m[3] = snap[3];
    cyc(10);
    chk_all();
    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom);
      eq.push_back(int'(d));
      i_host.mem[i] = d;
    end
    src = 1'b1;
    cyc(4);
    reload();
    chk_all();
    src = 1'b0;
    cyc(4);
    wr(7'h07, 16'h1234);
    chk_all();
    final_report();
  end
endmodule
`default_nettype wire
